//--- hw/limit_pkg.sv
package limit_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_SHUNT_UNDER = 8'h0d;
    localparam logic [7:0] OFS_BUS_OVER = 8'h0e;
    localparam logic [7:0] OFS_BUS_UNDER = 8'h0f;
    localparam logic [7:0] OFS_TEMP_OVER = 8'h10;
    localparam logic [7:0] OFS_POWER_OVER = 8'h11;
    localparam logic [7:0] OFS_MAKER_ID = 8'h3e;
    localparam logic [7:0] OFS_PART_ID = 8'h3f;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] RST_SHUNT_UNDER = 16'h8000;
    localparam logic [14:0] RST_BUS_OVER = 15'h7fff;
    localparam logic [14:0] RST_BUS_UNDER = 15'h0000;
    localparam logic [11:0] RST_TEMP_FIELD = 12'h07ff;
    localparam logic [15:0] RST_POWER_OVER = 16'hffff;
    localparam logic [7:0] RST_FLAGS = 8'h00;

    // ----------------------------------------
    // Field positions and widths
    // ----------------------------------------
    localparam int unsigned BUS_FIELD_W = 15;
    localparam int unsigned TEMP_FIELD_LSB = 4;
    localparam int unsigned REV_FIELD_W = 4;
    localparam int unsigned POWER_ALIGN_SHIFT = 8;
    localparam int unsigned FLAG_POWER_HIGH = 2;
    localparam int unsigned FLAG_BUS_LOW = 3;
    localparam int unsigned FLAG_BUS_HIGH = 4;
    localparam int unsigned FLAG_SHUNT_LOW = 5;
    localparam int unsigned FLAG_OVERHEAT = 7;
    localparam logic [7:0] FLAG_USED_MASK = 8'hbc;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic shunt_upd;
        logic [15:0] shunt;
        logic bus_upd;
        logic [15:0] bus;
        logic temp_upd;
        logic [11:0] temp;
        logic power_upd;
        logic [23:0] power;
    } meas_t;

    typedef struct packed {
        logic [15:0] shunt_under;
        logic [14:0] bus_over;
        logic [14:0] bus_under;
        logic [11:0] temp_field;
        logic [15:0] power_over;
        logic [7:0] flags;
        logic [15:0] rdata;
        logic rvalid;
    } bank_state_t;

    localparam bank_state_t STATE_RST = '{
        shunt_under: RST_SHUNT_UNDER,
        bus_over: RST_BUS_OVER,
        bus_under: RST_BUS_UNDER,
        temp_field: RST_TEMP_FIELD,
        power_over: RST_POWER_OVER,
        flags: RST_FLAGS,
        rdata: 16'h0000,
        rvalid: 1'b0
    };

endpackage

//--- hw/threshold_compare.sv
`timescale 1ns/1ns
module threshold_compare (
    input wire limit_pkg::meas_t meas,
    input wire limit_pkg::bank_state_t bank,
    output logic [7:0] eval_mask,
    output logic [7:0] hit_vec
);

    logic [15:0] power_aligned;

    // Power result scaled down to threshold units
    assign power_aligned = 16'(meas.power >> limit_pkg::POWER_ALIGN_SHIFT);

    // One verdict per measurement update, against the thresholds held now
    always_comb begin
        eval_mask = 8'h00;
        hit_vec = 8'h00;
        // [RULE_02] signed shunt compare
        // [RULE_14] shunt low verdict
        eval_mask[limit_pkg::FLAG_SHUNT_LOW] = meas.shunt_upd;
        hit_vec[limit_pkg::FLAG_SHUNT_LOW] = $signed(meas.shunt) < $signed(bank.shunt_under);
        // [RULE_03] unsigned bus high
        // [RULE_13] bus high verdict
        eval_mask[limit_pkg::FLAG_BUS_HIGH] = meas.bus_upd;
        hit_vec[limit_pkg::FLAG_BUS_HIGH] = meas.bus > {1'b0, bank.bus_over};
        // [RULE_04] unsigned bus low
        eval_mask[limit_pkg::FLAG_BUS_LOW] = meas.bus_upd;
        hit_vec[limit_pkg::FLAG_BUS_LOW] = meas.bus < {1'b0, bank.bus_under};
        // [RULE_07] direct temperature compare
        // [RULE_15] overheat verdict
        eval_mask[limit_pkg::FLAG_OVERHEAT] = meas.temp_upd;
        hit_vec[limit_pkg::FLAG_OVERHEAT] = $signed(meas.temp) > $signed(bank.temp_field);
        // [RULE_10] aligned power compare
        // [RULE_16] power high verdict
        eval_mask[limit_pkg::FLAG_POWER_HIGH] = meas.power_upd;
        hit_vec[limit_pkg::FLAG_POWER_HIGH] = power_aligned > bank.power_over;
    end

endmodule // threshold_compare

//--- hw/limit_bank.sv
`timescale 1ns/1ns
// Contract
// [RULE_01] Shunt under-limit is a 16-bit read-write register at 0x0D resetting to 0x8000.
// [RULE_02] The shunt threshold is two's complement in the same scale as the shunt result.
// [RULE_03] Bus over-limit at 0x0E resets to 0x7FFF and holds an unsigned 15-bit threshold.
// [RULE_04] Bus under-limit at 0x0F resets to zero and holds an unsigned 15-bit threshold.
// [RULE_05] Bit 15 of both bus threshold registers always reads zero whatever is written.
// [RULE_06] Temperature over-limit at 0x10 holds a signed 12-bit field in bits 15:4, reset 0x7FF.
// [RULE_07] The temperature field is compared with the die temperature result as it stands.
// [RULE_08] Bits 3:0 of the temperature over-limit register reset to zero and read zero.
// [RULE_09] Power over-limit at 0x11 is a 16-bit read-write unsigned threshold resetting to 0xFFFF.
// [RULE_10] One power threshold step equals 256 power result steps, so the result is shifted down.
// [RULE_11] The maker identity register at 0x3E is a fixed read-only two-character code.
// [RULE_12] Register 0x3F returns a fixed 12-bit part code over a 4-bit revision code.
// [RULE_13] Bus high sets flag bit 4 and bus low sets flag bit 3, cleared by a diagnostic read when latched.
// [RULE_14] Shunt below its limit sets flag bit 5, cleared by a diagnostic read when latched.
// [RULE_15] Temperature above its limit sets flag bit 7, cleared by a diagnostic read when latched.
// [RULE_16] Power above its limit sets flag bit 2, cleared by a diagnostic read when latched.
// [RULE_17] Each comparison runs once per update with the threshold held at that moment.
module limit_bank #(
    parameter logic [15:0] MAKER_CODE = 16'h4142,
    parameter logic [11:0] PART_CODE = 12'h0a5c,
    parameter logic [3:0] REV_CODE = 4'h3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire limit_pkg::reg_req_t reg_req,
    input wire limit_pkg::meas_t meas,
    input wire logic alert_latch_enable,
    input wire logic diag_read,
    output logic [15:0] rd_data_ff,
    output logic rd_valid_ff,
    output logic [7:0] alert_flags_ff
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (limit_pkg::TEMP_FIELD_LSB != limit_pkg::REV_FIELD_W) begin : g_bad_layout
        $error("temperature field must sit above four reserved bits");
    end

    // ----------------------------------------
    // State and comparator
    // ----------------------------------------
    limit_pkg::bank_state_t st_ff;
    limit_pkg::bank_state_t nxt_st;
    logic [7:0] eval_mask;
    logic [7:0] hit_vec;

    threshold_compare u_compare (
        .meas(meas),
        .bank(st_ff),
        .eval_mask(eval_mask),
        .hit_vec(hit_vec)
    );

    // Read word for one offset, zero when unmapped
    function automatic logic [15:0] read_word(
        input logic [7:0] addr,
        input limit_pkg::bank_state_t s
    );
        logic [15:0] w;
        w = 16'h0000;
        case (addr)
            limit_pkg::OFS_SHUNT_UNDER: w = s.shunt_under;
            // [RULE_05] bit 15 reads zero
            limit_pkg::OFS_BUS_OVER: w = {1'b0, s.bus_over};
            limit_pkg::OFS_BUS_UNDER: w = {1'b0, s.bus_under};
            // [RULE_08] low nibble reads zero
            limit_pkg::OFS_TEMP_OVER: w = {s.temp_field, 4'h0};
            limit_pkg::OFS_POWER_OVER: w = s.power_over;
            // [RULE_11] fixed maker code
            limit_pkg::OFS_MAKER_ID: w = MAKER_CODE;
            // [RULE_12] part over revision
            limit_pkg::OFS_PART_ID: w = {PART_CODE, REV_CODE};
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        // Register writes; identity and unmapped offsets ignore them
        if (reg_req.wr) begin
            case (reg_req.addr)
                // [RULE_01] full-width shunt limit
                limit_pkg::OFS_SHUNT_UNDER: nxt_st.shunt_under = reg_req.wdata;
                // [RULE_03] bus high field
                limit_pkg::OFS_BUS_OVER: nxt_st.bus_over = reg_req.wdata[14:0];
                // [RULE_04] bus low field
                limit_pkg::OFS_BUS_UNDER: nxt_st.bus_under = reg_req.wdata[14:0];
                // [RULE_06] temperature field only
                limit_pkg::OFS_TEMP_OVER: nxt_st.temp_field = reg_req.wdata[15:4];
                // [RULE_09] power limit word
                limit_pkg::OFS_POWER_OVER: nxt_st.power_over = reg_req.wdata;
                default: ;
            endcase
        end
        // Read answer one cycle after the request
        if (reg_req.rd) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = read_word(reg_req.addr, st_ff);
        end
        // [RULE_17] flags follow each update
        for (int b = 0; b < 8; b++) begin
            if (limit_pkg::FLAG_USED_MASK[b]) begin
                if (alert_latch_enable) begin
                    // Read clears, a fresh hit in the same cycle wins
                    if (diag_read) begin
                        nxt_st.flags[b] = 1'b0;
                    end
                    if (eval_mask[b] && hit_vec[b]) begin
                        nxt_st.flags[b] = 1'b1;
                    end
                end else if (eval_mask[b]) begin
                    nxt_st.flags[b] = hit_vec[b];
                end
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_ff <= limit_pkg::STATE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state flops
    assign rd_data_ff = st_ff.rdata;
    assign rd_valid_ff = st_ff.rvalid;
    assign alert_flags_ff = st_ff.flags;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_write(logic [7:0] a);
        reg_req.wr && reg_req.addr == a;
    endsequence

    sequence s_read(logic [7:0] a);
        reg_req.rd && !reg_req.wr && reg_req.addr == a;
    endsequence

    property p_reset_values;
        @(posedge ref_clk) $past(!rst_n) && rst_n |->
            st_ff.shunt_under == limit_pkg::RST_SHUNT_UNDER &&
            st_ff.bus_over == limit_pkg::RST_BUS_OVER &&
            st_ff.temp_field == limit_pkg::RST_TEMP_FIELD &&
            st_ff.power_over == limit_pkg::RST_POWER_OVER && st_ff.flags == 8'h00;
    endproperty

    a_reset_values_seen: assert property (p_reset_values) // [RULE_01]
        else $error("threshold reset values wrong");

    a_shunt_write_read: assert property ( // [RULE_01]
        s_write(limit_pkg::OFS_SHUNT_UNDER) ##1 !reg_req.wr ##1 s_read(limit_pkg::OFS_SHUNT_UNDER)
        |=> rd_valid_ff && rd_data_ff == $past(reg_req.wdata, 3))
        else $error("shunt limit does not read back");

    a_bus_reserved_zero: assert property ( // [RULE_05]
        s_read(limit_pkg::OFS_BUS_OVER) or s_read(limit_pkg::OFS_BUS_UNDER)
        |=> rd_valid_ff && !rd_data_ff[15])
        else $error("bus limit bit 15 not zero");

    a_temp_field_write: assert property ( // [RULE_06]
        s_write(limit_pkg::OFS_TEMP_OVER) |=> st_ff.temp_field == $past(reg_req.wdata[15:4]))
        else $error("temperature field not stored");

    a_temp_low_zero: assert property ( // [RULE_08]
        s_read(limit_pkg::OFS_TEMP_OVER) |=> rd_data_ff[3:0] == 4'h0)
        else $error("temperature low bits not zero");

    a_maker_code_read: assert property ( // [RULE_11]
        s_read(limit_pkg::OFS_MAKER_ID) |=> rd_valid_ff && rd_data_ff == MAKER_CODE)
        else $error("maker code wrong");

    a_part_code_read: assert property ( // [RULE_12]
        s_read(limit_pkg::OFS_PART_ID) |=> rd_data_ff == {PART_CODE, REV_CODE})
        else $error("part code wrong");

    a_power_flag_set: assert property ( // [RULE_16]
        meas.power_upd && meas.power[23:8] > st_ff.power_over
        |=> alert_flags_ff[limit_pkg::FLAG_POWER_HIGH])
        else $error("power flag missed");

    a_bus_high_set: assert property ( // [RULE_13]
        meas.bus_upd && meas.bus > {1'b0, st_ff.bus_over} |=> alert_flags_ff[4])
        else $error("bus high flag missed");

    a_shunt_low_set: assert property ( // [RULE_14]
        meas.shunt_upd && $signed(meas.shunt) < $signed(st_ff.shunt_under)
        |=> alert_flags_ff[5])
        else $error("shunt low flag missed");

    a_overheat_set: assert property ( // [RULE_15]
        meas.temp_upd && $signed(meas.temp) > $signed(st_ff.temp_field)
        |=> alert_flags_ff[7])
        else $error("overheat flag missed");

    a_latch_read_clear: assert property ( // [RULE_13]
        alert_latch_enable && diag_read && !meas.bus_upd
        |=> !alert_flags_ff[3] && !alert_flags_ff[4])
        else $error("latched bus flags not cleared");

    a_flags_hold_idle: assert property ( // [RULE_17]
        !meas.shunt_upd && !meas.bus_upd && !meas.temp_upd && !meas.power_upd &&
        !(alert_latch_enable && diag_read) |=> $stable(alert_flags_ff))
        else $error("flags moved without update");

endmodule // limit_bank

//--- sim/reg_host.sv
`timescale 1ns/1ns
module reg_host (
    input wire logic ref_clk,
    output limit_pkg::reg_req_t reg_req,
    input wire logic [15:0] rd_data_ff,
    input wire logic rd_valid_ff
);
    // Port idle until the first request
    initial begin
        reg_req = '0;
    end

    // Word write, taken at the edge after it is presented
    task automatic write_word(input logic [7:0] addr, input logic [15:0] data);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // Word read, answer stands just after the taking edge
    task automatic read_word(input logic [7:0] addr, output logic [15:0] data, output logic ok);
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h5a5a};
        @(posedge ref_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 16'ha5a5};
        #1;
        ok = rd_valid_ff;
        data = rd_data_ff;
    endtask
endmodule // reg_host

//--- sim/tb.sv
`timescale 1ns/1ns
module tb;
    localparam logic [15:0] MAKER = 16'h6d6b; // Arbitrary value
    localparam logic [11:0] PART = 12'h0c3d; // Arbitrary value
    localparam logic [3:0] REV = 4'h9; // Arbitrary value
    logic ref_clk, rst_n, alert_latch_enable, diag_read, ok, rd_valid_ff;
    limit_pkg::reg_req_t reg_req;
    limit_pkg::meas_t meas;
    logic [15:0] rd_data_ff, got;
    logic [7:0] alert_flags_ff, flags_exp;
    logic [31:0] seed;
    logic [15:0] lim [5];
    int errors, comparisons, i;
    logic [7:0] offs [5] = '{8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11};
    logic [15:0] wmask [5] = '{16'hffff, 16'h7fff, 16'h7fff, 16'hfff0, 16'hffff};
    logic [7:0] fmask [4] = '{8'h20, 8'h18, 8'h80, 8'h04};

    limit_bank #(.MAKER_CODE(MAKER), .PART_CODE(PART), .REV_CODE(REV)) limit_bank_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .meas(meas),
        .alert_latch_enable(alert_latch_enable), .diag_read(diag_read),
        .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .alert_flags_ff(alert_flags_ff)
    );
    reg_host reg_host_inst (
        .ref_clk(ref_clk), .reg_req(reg_req), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff)
    );

    // Clock and hang guard
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;
    initial begin
        #1_500_000;
        errors++;
        test_done();
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        reg_host_inst.read_word(a, got, ok);
        chk("read valid", 16'h0001, {15'h0000, ok});
        chk("read data", exp, got);
    endtask

    // Write a threshold and keep the expected readback
    task automatic wr(input int k, input logic [15:0] d);
        reg_host_inst.write_word(offs[k], d);
        lim[k] = d & wmask[k];
    endtask

    // One measurement pulse, then the flags one cycle later
    task automatic update(input int src, input logic [23:0] v);
        logic [7:0] b;
        limit_pkg::meas_t m;
        b = 8'h00;
        m = '0;
        case (src)
            0: begin m.shunt_upd = 1'b1; m.shunt = v[15:0]; end
            1: begin m.bus_upd = 1'b1; m.bus = v[15:0]; end
            2: begin m.temp_upd = 1'b1; m.temp = v[11:0]; end
            default: begin m.power_upd = 1'b1; m.power = v; end
        endcase
        case (src)
            0: b[5] = $signed(v[15:0]) < $signed(lim[0]);
            1: begin b[4] = v[15:0] > lim[1]; b[3] = v[15:0] < lim[2]; end
            2: b[7] = $signed(v[11:0]) > $signed(lim[3][15:4]);
            default: b[2] = v[23:8] > lim[4];
        endcase
        flags_exp = alert_latch_enable ? (flags_exp | b) : ((flags_exp & ~fmask[src]) | b);
        @(posedge ref_clk);
        meas <= m;
        @(posedge ref_clk);
        meas <= '0;
        #1;
        chk("alert flags", {8'h00, flags_exp}, {8'h00, alert_flags_ff});
    endtask

    task automatic diag();
        @(posedge ref_clk);
        diag_read <= 1'b1;
        @(posedge ref_clk);
        diag_read <= 1'b0;
        #1;
        if (alert_latch_enable) flags_exp = 8'h00;
        chk("flags after read", {8'h00, flags_exp}, {8'h00, alert_flags_ff});
    endtask

    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        alert_latch_enable = 1'b0;
        diag_read = 1'b0;
        meas = '0;
        seed = 32'hd8c7_40d7;
        flags_exp = 8'h00;
        // Temperature limit reads 0x7FF0: field 0x7FF over a low nibble that reads zero
        lim = '{16'h8000, 16'h7fff, 16'h0000, 16'h7ff0, 16'hffff};
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset values, identity and unmapped reads
        for (i = 0; i < 5; i++) rdchk(offs[i], lim[i]);
        reg_host_inst.write_word(8'h3e, 16'h0000);
        reg_host_inst.write_word(8'h3f, 16'h0000);
        rdchk(8'h3e, MAKER);
        rdchk(8'h3f, {PART, REV});
        rdchk(8'h20, 16'h0000);
        // All ones, reserved bits must read zero
        for (i = 0; i < 5; i++) begin
            wr(i, 16'hffff);
            rdchk(offs[i], lim[i]);
        end
        repeat (40) begin
            seed = xs(seed);
            i = int'(seed % 5);
            wr(i, seed[31:16]);
            rdchk(offs[i], lim[i]);
        end
        // Random compares, unlatched then latched
        for (int l = 0; l < 2; l++) begin
            @(posedge ref_clk);
            alert_latch_enable <= l[0];
            #1;
            repeat (80) begin
                seed = xs(seed);
                if (seed[3:0] == 4'h0) wr(int'(seed[6:4] % 5), seed[31:16]);
                update(int'(seed[9:8]), seed[31:8]);
                if (seed[12:11] == 2'b00) diag();
            end
            // Equal values are no hit
            update(1, {8'h00, lim[1]});
            update(2, {12'h000, lim[3][15:4]});
            update(3, {lim[4], 8'hff});
            diag();
        end
        test_done();
    end
endmodule // tb
